// >>> common/wdit_pkg.sv
// package for the watchdog / interval timer: offsets, field layout, reset values and counts.
// assumes a 32-bit avalon-mm register slave and a single system clock.
package wdit_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] WDIT_OFF_CTL = 4'h0;
  localparam logic [3:0] WDIT_OFF_STAT = 4'h4;

  // control register field positions
  localparam int WDIT_CTL_KEY_LSB = 4;
  localparam int WDIT_CTL_EN_BIT = 3;
  localparam int WDIT_CTL_MODE_BIT = 2;
  localparam int WDIT_CTL_INT_LSB = 0;

  // status register field positions
  localparam int WDIT_STAT_FLAG_BIT = 0;
  localparam int WDIT_STAT_IE_BIT = 1;
  localparam int WDIT_STAT_ARMED_BIT = 2;
  localparam int WDIT_STAT_PEND_BIT = 3;

  // ****************************************************************
  // clear keys and reset values
  // ****************************************************************
  localparam logic [3:0] WDIT_KEY_FIRST = 4'hA;
  localparam logic [3:0] WDIT_KEY_SECOND = 4'h5;
  localparam logic [14:0] WDIT_CNT_RESET = 15'h0000;
  localparam logic [31:0] WDIT_RDATA_NONE = 32'h0000_0000;

  // terminal counts minus one, by interval code
  localparam logic [14:0] WDIT_TERM_M1_0 = 15'h003F;
  localparam logic [14:0] WDIT_TERM_M1_1 = 15'h01FF;
  localparam logic [14:0] WDIT_TERM_M1_2 = 15'h1FFF;
  localparam logic [14:0] WDIT_TERM_M1_3 = 15'h7FFF;

  // ****************************************************************
  // power modes
  // ****************************************************************
  localparam logic [2:0] WDIT_PWR_ACTIVE = 3'h0;
  localparam logic [2:0] WDIT_PWR_IDLE = 3'h1;
  localparam logic [2:0] WDIT_PWR_LIGHT = 3'h2;
  localparam logic [2:0] WDIT_PWR_LOW = 3'h3;
  localparam logic [2:0] WDIT_PWR_DEEP = 3'h4;

  typedef struct packed {
    logic en;
    logic mode;
    logic [1:0] interval;
  } wdit_ctl_t;

  localparam wdit_ctl_t WDIT_CTL_RESET = '{en: 1'b0, mode: 1'b0, interval: 2'h0};

endpackage

// >>> rtl/wdit_watchdog_unit.sv
// watchdog_unit: watchdog / interval timer on a 15-bit counter ticked by the low-speed oscillator.
// assumes lsosc is an asynchronous pin, pwr_mode comes from logic on clk,
// and the register bus is an avalon-mm master on clk.

module wdit_watchdog_unit (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // low-speed oscillator pin and power state
  input wire logic lsosc,
  input wire logic [2:0] pwr_mode,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // system outputs
  output logic sys_reset_req,
  output logic wd_timer_irq
);

  // ****************************************************************
  // low-speed oscillator sampling
  // ****************************************************************
  logic ls_s1;
  logic ls_s2;
  logic ls_s3;
  logic ls_level;
  wire ls_agree = (ls_s2 == ls_s3);
  wire ls_change = ls_agree && (ls_s2 != ls_level);
  wire ls_tick = ls_change && ls_s2;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ls_s1 <= 1'b0;
      ls_s2 <= 1'b0;
      ls_s3 <= 1'b0;
      ls_level <= 1'b0;
    end else begin
      ls_s1 <= lsosc;
      ls_s2 <= ls_s1;
      ls_s3 <= ls_s2;
      if (ls_agree) begin
        ls_level <= ls_s2;
      end
    end
  end

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one wait cycle for every access keeps readdata and waitrequest straight from flops
  logic [3:0] addr_q;
  wire bus_req = avs_read || avs_write;
  wire bus_fire = bus_req && !avs_waitrequest;
  wire wr_ctl = avs_write && bus_fire && (avs_address == wdit_pkg::WDIT_OFF_CTL);
  wire wr_stat = avs_write && bus_fire && (avs_address == wdit_pkg::WDIT_OFF_STAT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  wdit_pkg::wdit_ctl_t ctl;
  wdit_pkg::wdit_ctl_t next_ctl;
  logic irq_en;
  wire [3:0] wr_key = avs_writedata[wdit_pkg::WDIT_CTL_KEY_LSB +: 4];
  wire wr_en = avs_writedata[wdit_pkg::WDIT_CTL_EN_BIT];
  wire wr_mode = avs_writedata[wdit_pkg::WDIT_CTL_MODE_BIT];
  wire [1:0] wr_int = avs_writedata[wdit_pkg::WDIT_CTL_INT_LSB +: 2];
  wire wd_locked = ctl.en && !ctl.mode;
  wire en_start = wr_ctl && ctl.mode && !ctl.en && wr_en;

  always_comb begin
    next_ctl = ctl;
    if (wr_ctl) begin
      next_ctl.interval = wr_int;
      if (!wd_locked) begin
        next_ctl.mode = wr_mode;
        next_ctl.en = wr_en;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= wdit_pkg::WDIT_CTL_RESET;
      irq_en <= 1'b0;
    end else begin
      ctl <= next_ctl;
      if (wr_stat) begin
        irq_en <= avs_writedata[wdit_pkg::WDIT_STAT_IE_BIT];
      end
    end
  end

  // ****************************************************************
  // clear sequence
  // ****************************************************************
  // key writes only count while enabled, judged on the enable held before the write
  logic armed;
  wire key_ok = wr_ctl && ctl.en;
  wire wd_clear = key_ok && !ctl.mode && armed && (wr_key == wdit_pkg::WDIT_KEY_SECOND);
  wire tm_clear = key_ok && ctl.mode && wr_key[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
    end else if (key_ok && !ctl.mode) begin
      armed <= (wr_key == wdit_pkg::WDIT_KEY_FIRST);
    end else if (ls_change) begin
      armed <= 1'b0;
    end
  end

  // ****************************************************************
  // counter and expiry
  // ****************************************************************
  logic [14:0] count;
  logic [14:0] term_m1;
  wire sleep_hold = (pwr_mode == wdit_pkg::WDIT_PWR_LOW) || (pwr_mode == wdit_pkg::WDIT_PWR_DEEP);
  wire awake = (pwr_mode == wdit_pkg::WDIT_PWR_ACTIVE) || (pwr_mode == wdit_pkg::WDIT_PWR_IDLE);
  wire light = (pwr_mode == wdit_pkg::WDIT_PWR_LIGHT);
  wire cnt_clear = sleep_hold || wd_clear || tm_clear || en_start;
  wire expire = ls_tick && ctl.en && !cnt_clear && (count == term_m1);

  always_comb begin
    case (ctl.interval)
      2'h0: term_m1 = wdit_pkg::WDIT_TERM_M1_0;
      2'h1: term_m1 = wdit_pkg::WDIT_TERM_M1_1;
      2'h2: term_m1 = wdit_pkg::WDIT_TERM_M1_2;
      2'h3: term_m1 = wdit_pkg::WDIT_TERM_M1_3;
      default: term_m1 = wdit_pkg::WDIT_TERM_M1_3;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= wdit_pkg::WDIT_CNT_RESET;
    end else if (cnt_clear) begin
      count <= wdit_pkg::WDIT_CNT_RESET;
    end else if (expire) begin
      count <= wdit_pkg::WDIT_CNT_RESET;
    end else if (ls_tick && ctl.en) begin
      count <= count + 15'h0001;
    end
  end

  // ****************************************************************
  // reset request and timer flag
  // ****************************************************************
  // an expiry in light sleep is held, unless a clear or low or deep sleep drops it, and fires the moment the chip wakes
  logic pend;
  logic flag;
  wire wd_expire = expire && !ctl.mode;
  wire next_flag = (expire && ctl.mode) ||
    (flag && !(wr_stat && avs_writedata[wdit_pkg::WDIT_STAT_FLAG_BIT]));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 1'b0;
      flag <= 1'b0;
      sys_reset_req <= 1'b0;
      wd_timer_irq <= 1'b0;
    end else begin
      flag <= next_flag;
      wd_timer_irq <= flag && irq_en;
      if (wd_expire && light) begin
        pend <= 1'b1;
      end else if (wd_clear || sleep_hold) begin
        pend <= 1'b0;
      end
      if ((wd_expire && awake) || (pend && awake)) begin
        sys_reset_req <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  wire [31:0] rd_ctl = {24'h000000, 4'h0, ctl.en, ctl.mode, ctl.interval};
  wire [31:0] rd_stat = {28'h0000000, pend, armed, irq_en, flag};
  wire [31:0] rd_sel = (avs_address == wdit_pkg::WDIT_OFF_CTL) ? rd_ctl :
    (avs_address == wdit_pkg::WDIT_OFF_STAT) ? rd_stat : wdit_pkg::WDIT_RDATA_NONE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= wdit_pkg::WDIT_RDATA_NONE;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_sel;
    end
  end

endmodule

// >>> dv/wdit_wd_sva.sv
// checker for the watchdog unit: bus answer timing, read data and reset request.
// assumes it is bound to wdit_watchdog_unit and sees only its ports.
module wdit_wd_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // inputs
  input wire logic [2:0] pwr_mode,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  // outputs
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sys_reset_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  wire rd_done = avs_read && !avs_waitrequest;
  wire ctl_hit = avs_address == wdit_pkg::WDIT_OFF_CTL;
  wire stat_hit = avs_address == wdit_pkg::WDIT_OFF_STAT;
  // ********
  // assertions
  // ********
  chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  chk_rd_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (rd_done && !ctl_hit && !stat_hit |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_key_reads_zero: assert property (rd_done && ctl_hit |-> avs_readdata[31:4] == 28'h0)
    else $error("clear key or upper bits read back");
  chk_rst_sticky: assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped");
  chk_rst_awake: assert property ($rose(sys_reset_req) |-> $past(pwr_mode) <= wdit_pkg::WDIT_PWR_IDLE)
    else $error("reset request outside active or idle");
endmodule

bind wdit_watchdog_unit wdit_wd_sva wdit_wd_sva_i (.clk, .arst_n, .pwr_mode, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .sys_reset_req);

// >>> dv/wdit_watchdog_unit_bench.sv
// bench for the watchdog unit: avalon-mm accesses, expiry timing, clear keys, power modes.
// assumes the slow oscillator is made here at clk/8 and paused around key pairs.
module wdit_watchdog_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hold = 1'b1;
  logic [2:0] osc = 3'h0;
  logic [2:0] pwr_mode = 3'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rdv;
  logic avs_waitrequest;
  logic sys_reset_req;
  logic wd_timer_irq;
  int n_errors = 0;
  int num_checks = 0;
  int nrise = 0;
  int term[3] = '{64, 512, 8192};
  always #2.5 clk = ~clk;
  // paused slow clock keeps a key pair inside one half period
  always @(posedge clk) if (!hold) osc <= osc + 3'h1;
  always @(posedge clk) if (!hold && osc == 3'h3) nrise <= nrise + 1;
  wdit_watchdog_unit wdit_watchdog_unit_i (.clk, .arst_n, .lsosc(osc[2]), .pwr_mode, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sys_reset_req, .wd_timer_irq);
  // ********
  // tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask
  task automatic pause();
    hold <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic arm(input logic [31:0] ctl);
    pause();
    bus(1'b1, 4'h4, 32'h3);
    bus(1'b1, 4'h0, 32'h4);
    bus(1'b1, 4'h0, ctl);
    nrise = 0;
    hold <= 1'b0;
  endtask
  task automatic key(input logic [31:0] k2, input logic clr);
    pause();
    bus(1'b1, 4'h0, 32'hA8);
    rd(4'h4, 32'h4);
    bus(1'b1, 4'h0, k2);
    if (clr) nrise = 0;
    hold <= 1'b0;
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ********
  // tests
  // ********
  initial begin
    #450us;
    n_errors++;
    end_sim();
  end
  initial begin
    do_reset();
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'hFF);
    rd(4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'hA0);
    rd(4'h4, 32'h0);
    foreach (term[c]) begin
      arm(32'hC + c);
      wait (wd_timer_irq);
      @(posedge clk);
      check(nrise, term[c]);
      check(sys_reset_req, 32'h0);
      rd(4'h4, 32'h3);
    end
    arm(32'hC);
    wait (nrise == 32);
    pause();
    bus(1'b1, 4'h0, 32'h1C);
    hold <= 1'b0;
    wait (wd_timer_irq);
    check(nrise, 96);
    do_reset();
    bus(1'b1, 4'h0, 32'h8);
    wait (nrise > 40);
    key(32'h58, 1'b1);
    bus(1'b1, 4'h0, 32'h4);
    rd(4'h0, 32'h8);
    bus(1'b1, 4'h0, 32'h9);
    rd(4'h0, 32'h9);
    bus(1'b1, 4'h0, 32'h8);
    key(32'h58, 1'b1);
    // first key left alone across a slow level change must be dropped
    bus(1'b1, 4'h0, 32'hA8);
    repeat (12) @(posedge clk);
    rd(4'h4, 32'h0);
    wait (nrise == 40);
    key(32'h38, 1'b0);
    bus(1'b1, 4'h0, 32'h58);
    wait (sys_reset_req);
    check(nrise, 64);
    rd(4'h4, 32'h0);
    do_reset();
    bus(1'b1, 4'h0, 32'h8);
    nrise = 0;
    wait (nrise == 40);
    pwr_mode <= 3'h3;
    wait (nrise == 70);
    pwr_mode <= 3'h1;
    nrise = 0;
    wait (nrise == 60);
    check(sys_reset_req, 32'h0);
    rd(4'h0, 32'h8);
    pwr_mode <= 3'h2;
    wait (nrise == 70);
    check(sys_reset_req, 32'h0);
    pwr_mode <= 3'h0;
    repeat (3) @(posedge clk);
    check(sys_reset_req, 32'h1);
    end_sim();
  end
endmodule
